// *** core/thermal_mode_supervisor.sv ***
// supervisor for power modes, boot sequencing and thermal shutdown responses
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ns
`include "tms_defs.svh"
module thermal_mode_supervisor #(
	parameter int DUAL_PORT = 1
) (
	input  wire logic        CORE_CLK,
	input  wire logic        SYS_RST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire tms_pkg::sensors_t SENSORS,
	input  wire logic        OVERTEMP_HYSTERESIS,
	input  wire logic        ENABLE_UNDERVOLTAGE_INPUT,
	input  wire logic        SUPPLY_ABOVE_LOCKOUT,
	input  wire logic        BUS_ABOVE_DISCH_THRESHOLD,
	input  wire logic        BUS_FALLING,
	input  wire logic [2:0]  TEMPERATURE_SENSE_INPUT,
	input  wire logic        STRAP_DONE,
	input  wire logic [3:0]  CONFIG_STRAP_INDEX,
	output logic             BUCKBOOST_EN,
	output logic             PORT_A_CABLE_POWER_EN,
	output logic             PORT_B_CABLE_POWER_EN,
	output logic             DISCHARGE_EN,
	output logic             ERROR_RECOVERY,
	output logic             CPU_RESET,
	output logic             CPU_EN,
	output logic             PORT_B_EN,
	output logic             UPDATE_MODE,
	output logic             STRAP_MEASURE_REQ,
	output logic             CONFIG_LOAD_REQ,
	output logic [6:0]       CONFIG_MEM_ADDR,
	output logic             IRQ
);
	tms_pkg::state_t r;
	tms_pkg::state_t next_r;
	logic [9:0] events;
	logic       wr;
	logic       rd;
	logic       active_ok;

	always_comb begin
		next_r = r;
		// two-stage synchronizer, first stage read only by the second
		next_r.s1 = SENSORS;
		next_r.s2 = r.s1;
		next_r.ntc_prev = TEMPERATURE_SENSE_INPUT;
		wr = PSEL && PENABLE && PWRITE;
		rd = PSEL && !PENABLE && !PWRITE;
		active_ok = ENABLE_UNDERVOLTAGE_INPUT && SUPPLY_ABOVE_LOCKOUT;
		events = '0;
		events[`EV_BB] = r.s2.buckboost_overtemp;
		events[`EV_PA_CP] = r.s2.port_a_cable_power_overtemp;
		events[`EV_PB_CP] = r.s2.port_b_cable_power_overtemp && (DUAL_PORT != 0);
		events[`EV_DISCH] = r.s2.port_a_discharge_overtemp;
		events[`EV_MASTER] = r.s2.master_overtemp;
		// rising threshold crossings only: rising voltage is rising temperature
		for (int i = 0; i < 3; i++) begin
			events[`EV_NTC0 + i] = TEMPERATURE_SENSE_INPUT[i] && !r.ntc_prev[i];
		end
		next_r.strap_req = 1'b0;
		next_r.load_req = 1'b0;
		// mode sequencing; master overtemp and enable loss both force shutdown
		if (r.s2.master_overtemp || !active_ok) begin
			next_r.mode = tms_pkg::ST_SHUTDOWN;
		end else begin
			case (r.mode)
				tms_pkg::ST_SHUTDOWN: begin
					// re-entry waits for the hysteresis release after a master event
					if (OVERTEMP_HYSTERESIS) begin
						next_r.mode = tms_pkg::ST_STRAP;
						next_r.strap_req = 1'b1;
					end
				end
				tms_pkg::ST_STRAP: begin
					if (STRAP_DONE) begin
						next_r.strap_index = CONFIG_STRAP_INDEX;
						if (CONFIG_STRAP_INDEX == `UPDATE_INDEX) begin
							next_r.mode = tms_pkg::ST_UPDATE;
						end else begin
							next_r.mode = tms_pkg::ST_LOAD;
							next_r.load_req = 1'b1;
						end
					end
				end
				tms_pkg::ST_LOAD: begin
					if (r.ctrl[`CTRL_BOOT_ERR]) begin
						next_r.mode = tms_pkg::ST_FALLBACK;
						events[`EV_BOOT_ERR] = 1'b1;
					end else if (r.ctrl[`CTRL_BOOT_OK]) begin
						next_r.mode = tms_pkg::ST_RUN;
						events[`EV_BOOT_DONE] = 1'b1;
					end
				end
				tms_pkg::ST_RUN: next_r.mode = tms_pkg::ST_RUN;
				tms_pkg::ST_FALLBACK: next_r.mode = tms_pkg::ST_FALLBACK;
				tms_pkg::ST_UPDATE: next_r.mode = tms_pkg::ST_UPDATE;
				default: next_r.mode = tms_pkg::ST_SHUTDOWN;
			endcase
		end
		// discharge switch: open on overtemp, reclose on hysteresis with falling bus above threshold
		if (r.s2.port_a_discharge_overtemp) begin
			next_r.disch_open = 1'b1;
		end else if (r.disch_open && OVERTEMP_HYSTERESIS && BUS_FALLING
			&& BUS_ABOVE_DISCH_THRESHOLD) begin
			next_r.disch_open = 1'b0;
		end
		next_r.cpu_en = (next_r.mode != tms_pkg::ST_SHUTDOWN);
		next_r.cpu_reset = (next_r.mode == tms_pkg::ST_SHUTDOWN) || r.s2.master_overtemp;
		next_r.bb_en = next_r.cpu_en && !r.s2.buckboost_overtemp;
		next_r.pa_cp_en = next_r.cpu_en && !r.s2.port_a_cable_power_overtemp;
		next_r.port_b_en = (next_r.mode == tms_pkg::ST_RUN) && r.ctrl[`CTRL_DUAL]
			&& (DUAL_PORT != 0);
		next_r.pb_cp_en = next_r.port_b_en && !r.s2.port_b_cable_power_overtemp;
		next_r.disch_en = next_r.cpu_en && !next_r.disch_open;
		next_r.err_recovery = r.s2.buckboost_overtemp || r.s2.port_a_cable_power_overtemp
			|| (r.s2.port_b_cable_power_overtemp && (DUAL_PORT != 0));
		next_r.update_mode = (next_r.mode == tms_pkg::ST_UPDATE);
		// sticky status: write one to clear, a new event wins over the clear
		if (wr && PADDR == `OFF_STATUS) begin
			next_r.status = r.status & ~PWDATA[9:0];
		end
		next_r.status = next_r.status | events;
		if (wr && PADDR == `OFF_MASK) begin
			next_r.mask = PWDATA[9:0];
		end
		if (wr && PADDR == `OFF_CTRL) begin
			next_r.ctrl = PWDATA[2:0];
		end
		// outcome bits are cleared when the sequencer heads into shutdown from any mode but load
		if (r.mode != tms_pkg::ST_LOAD && next_r.mode == tms_pkg::ST_SHUTDOWN) begin
			next_r.ctrl[`CTRL_BOOT_OK] = 1'b0;
			next_r.ctrl[`CTRL_BOOT_ERR] = 1'b0;
		end
		// a set mask bit hides its status bit; the new mask acts at once
		next_r.irq = |(next_r.status & ~next_r.mask);
		// reads answer in the access cycle; zero wait states like the core bus
		next_r.pready = PSEL && !PENABLE;
		if (rd) begin
			case (PADDR)
				`OFF_STATUS: next_r.prdata = {22'h00_0000, r.status};
				`OFF_MASK: next_r.prdata = {22'h00_0000, r.mask};
				`OFF_CTRL: next_r.prdata = {29'h0000_0000, r.ctrl};
				`OFF_STATE: next_r.prdata = {18'h0_0000, r.s2, 6'h00, r.mode};
				`OFF_BOOT: next_r.prdata = {25'h000_0000, `EEPROM_ADDR}
					| {16'h0000, 12'h000, r.strap_index} << 8;
				`OFF_NTC: next_r.prdata = {29'h0000_0000, TEMPERATURE_SENSE_INPUT};
				`OFF_MEMINFO: next_r.prdata = {`ROM_KBYTES, `SRAM_KBYTES};
				default: next_r.prdata = 32'h0000_0000;
			endcase
		end else if (!PSEL) begin
			next_r.prdata = 32'h0000_0000;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			r <= '0;
			r.mode <= tms_pkg::ST_SHUTDOWN;
			r.cpu_reset <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign PRDATA = r.prdata;
	assign PREADY = r.pready;
	assign PSLVERR = `PSLVERR_NONE;
	assign BUCKBOOST_EN = r.bb_en;
	assign PORT_A_CABLE_POWER_EN = r.pa_cp_en;
	assign PORT_B_CABLE_POWER_EN = r.pb_cp_en;
	assign DISCHARGE_EN = r.disch_en;
	assign ERROR_RECOVERY = r.err_recovery;
	assign CPU_RESET = r.cpu_reset;
	assign CPU_EN = r.cpu_en;
	assign PORT_B_EN = r.port_b_en;
	assign UPDATE_MODE = r.update_mode;
	assign STRAP_MEASURE_REQ = r.strap_req;
	assign CONFIG_LOAD_REQ = r.load_req;
	assign CONFIG_MEM_ADDR = `EEPROM_ADDR;
	assign IRQ = r.irq;
endmodule

// *** pkg/tms_defs.svh ***
// register offsets, field positions, memory sizes and core clock rate of the thermal mode supervisor
`ifndef TMS_DEFS_SVH
`define TMS_DEFS_SVH
`define OFF_STATUS      12'h000
`define OFF_MASK        12'h004
`define OFF_CTRL        12'h008
`define OFF_STATE       12'h00C
`define OFF_BOOT        12'h010
`define OFF_NTC         12'h014
`define OFF_MEMINFO     12'h018
`define EV_BB           0
`define EV_PA_CP        1
`define EV_PB_CP        2
`define EV_DISCH        3
`define EV_MASTER       4
`define EV_NTC0         5
`define EV_BOOT_DONE    8
`define EV_BOOT_ERR     9
`define NUM_EV          10
`define CTRL_BOOT_OK    0
`define CTRL_BOOT_ERR   1
`define CTRL_DUAL       2
`define UPDATE_INDEX    4'h8
`define EEPROM_ADDR     7'h50
`define SRAM_KBYTES     16'h001B
`define ROM_KBYTES      16'h00A0
`define OTP_BYTES       16'h0200
`define CORE_CLK_MHZ    24
`define PSLVERR_NONE    1'b0
`endif

// *** pkg/tms_pkg.sv ***
// types shared by the thermal mode supervisor
package tms_pkg;
	typedef enum logic [2:0] {
		ST_SHUTDOWN = 3'b000,
		ST_STRAP    = 3'b001,
		ST_LOAD     = 3'b010,
		ST_RUN      = 3'b011,
		ST_FALLBACK = 3'b100,
		ST_UPDATE   = 3'b101
	} mode_t;
	typedef struct packed {
		logic buckboost_overtemp;
		logic port_a_cable_power_overtemp;
		logic port_b_cable_power_overtemp;
		logic port_a_discharge_overtemp;
		logic master_overtemp;
	} sensors_t;
	typedef struct packed {
		mode_t       mode;
		sensors_t    s1;
		sensors_t    s2;
		logic [9:0]  status;
		logic [9:0]  mask;
		logic [2:0]  ctrl;
		logic [3:0]  strap_index;
		logic        disch_open;
		logic        bb_en;
		logic        pa_cp_en;
		logic        pb_cp_en;
		logic        disch_en;
		logic        err_recovery;
		logic        cpu_reset;
		logic        cpu_en;
		logic        port_b_en;
		logic        update_mode;
		logic        strap_req;
		logic        load_req;
		logic        irq;
		logic [31:0] prdata;
		logic        pready;
		logic [2:0]  ntc_prev;
	} state_t;
endpackage

// *** dv/tms_properties.sv ***
// concurrent checks on the supervisor's ports
`timescale 1ns/1ns
module tms_properties (
	input wire logic              CORE_CLK,
	input wire logic              SYS_RST,
	input wire tms_pkg::sensors_t SENSORS,
	input wire logic              ENABLE_UNDERVOLTAGE_INPUT,
	input wire logic              SUPPLY_ABOVE_LOCKOUT,
	input wire logic [3:0]        CONFIG_STRAP_INDEX,
	input wire logic              BUCKBOOST_EN,
	input wire logic              PORT_A_CABLE_POWER_EN,
	input wire logic              DISCHARGE_EN,
	input wire logic              ERROR_RECOVERY,
	input wire logic              CPU_RESET,
	input wire logic              CPU_EN,
	input wire logic              UPDATE_MODE,
	input wire logic              STRAP_MEASURE_REQ,
	input wire logic [6:0]        CONFIG_MEM_ADDR
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);
	// four samples cover the two-flop synchroniser plus the output register
	sequence hot4(s);
		s [*4];
	endsequence
	a_bb_off: assert property (hot4(SENSORS.buckboost_overtemp) |-> !BUCKBOOST_EN && ERROR_RECOVERY)
		else $error("buck-boost still on while hot");
	a_pa_cable_open: assert property (hot4(SENSORS.port_a_cable_power_overtemp) |-> !PORT_A_CABLE_POWER_EN && ERROR_RECOVERY)
		else $error("port a cable power still on while hot");
	a_disch_open: assert property (hot4(SENSORS.port_a_discharge_overtemp) |-> !DISCHARGE_EN)
		else $error("discharge switch closed while hot");
	a_master_reset: assert property (hot4(SENSORS.master_overtemp) |-> CPU_RESET && !CPU_EN)
		else $error("processor running during master overtemp");
	a_enable_off: assert property (!ENABLE_UNDERVOLTAGE_INPUT [*2] |-> !CPU_EN)
		else $error("processor enabled with enable input low");
	a_active_gate: assert property ($rose(CPU_EN) |-> $past(ENABLE_UNDERVOLTAGE_INPUT && SUPPLY_ABOVE_LOCKOUT))
		else $error("active mode entered without enable and supply");
	a_strap_first: assert property ($rose(CPU_EN) |-> STRAP_MEASURE_REQ)
		else $error("boot did not start with strap measurement");
	a_update_idx: assert property ($rose(UPDATE_MODE) |-> $past(CONFIG_STRAP_INDEX) == 4'h8)
		else $error("update mode without index eight");
	a_eeprom_addr: assert property (!$past(SYS_RST) |-> CONFIG_MEM_ADDR == 7'h50)
		else $error("wrong memory target address");
endmodule
bind thermal_mode_supervisor tms_properties i_tms_properties (.*);

// *** dv/tms_partner.sv ***
// strap resistance measurement model answering the supervisor
`timescale 1ns/1ns
module tms_partner #(
	parameter int LAT = 4
) (
	input  wire logic       CORE_CLK,
	input  wire logic       STRAP_MEASURE_REQ,
	input  wire logic [3:0] strap_sel,
	output logic            STRAP_DONE,
	output logic      [3:0] CONFIG_STRAP_INDEX
);
	int cnt = 0;
	initial begin
		STRAP_DONE = 1'b0;
		CONFIG_STRAP_INDEX = 4'h0;
	end
	// index only valid with done; otherwise it toggles so stale values cannot pass
	always @(posedge CORE_CLK) begin
		STRAP_DONE <= (cnt == 1);
		CONFIG_STRAP_INDEX <= (cnt == 1) ? strap_sel : ~CONFIG_STRAP_INDEX;
		if (STRAP_MEASURE_REQ) cnt <= LAT;
		else if (cnt != 0) cnt <= cnt - 1;
	end
endmodule

// *** dv/tb_top.sv ***
// self-checking bench of the thermal mode supervisor
`timescale 1ns/1ns
`include "tms_defs.svh"
module tb_top;
	typedef struct packed {tms_pkg::sensors_t s; logic [3:0] m; logic [4:0] b;} row_t;
	logic CORE_CLK = 0, SYS_RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, IRQ;
	logic OVERTEMP_HYSTERESIS = 0, ENABLE_UNDERVOLTAGE_INPUT = 0, SUPPLY_ABOVE_LOCKOUT = 0;
	logic BUS_ABOVE_DISCH_THRESHOLD = 0, BUS_FALLING = 0, STRAP_DONE, CONFIG_LOAD_REQ;
	logic BUCKBOOST_EN, PORT_A_CABLE_POWER_EN, PORT_B_CABLE_POWER_EN, DISCHARGE_EN;
	logic ERROR_RECOVERY, CPU_RESET, CPU_EN, PORT_B_EN, UPDATE_MODE, STRAP_MEASURE_REQ;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h0000_0000, PRDATA, q;
	logic [2:0] TEMPERATURE_SENSE_INPUT = 3'h0;
	logic [3:0] CONFIG_STRAP_INDEX, strap_sel = 4'h3;
	logic [6:0] CONFIG_MEM_ADDR;
	tms_pkg::sensors_t SENSORS = '0;
	int failures = 0, tests_run = 0;
	row_t rows[3] = '{'{5'h10, 4'h8, 5'h00}, '{5'h08, 4'h4, 5'h01}, '{5'h04, 4'h2, 5'h02}};
	thermal_mode_supervisor #(.DUAL_PORT(1)) i_thermal_mode_supervisor (.*);
	tms_partner #(.LAT(4)) i_tms_partner (.*);
	initial forever #4 CORE_CLK = ~CORE_CLK;
	task w(input int n);
		repeat (n) @(posedge CORE_CLK);
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("MISMATCH %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// holds the request until pready is sampled high; no latency assumed
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge CORE_CLK);
		{PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {1'b1, 1'b0, wr, a, d};
		@(posedge CORE_CLK);
		PENABLE <= 1'b1;
		do @(posedge CORE_CLK); while (PREADY !== 1'b1);
		q = PRDATA;
		{PSEL, PENABLE} <= 2'h0;
	endtask
	task boot(input logic [3:0] x);
		strap_sel <= x;
		for (int i = 0; i < 80 && !(CONFIG_LOAD_REQ || (x == 4'h8 && UPDATE_MODE)); i++) w(1);
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#100000;
		failures++;
		stop_test();
	end
	initial begin
		w(5);
		SYS_RST <= 0;
		w(1);
		chk({CPU_RESET, CPU_EN}, 2'h2);
		{ENABLE_UNDERVOLTAGE_INPUT, OVERTEMP_HYSTERESIS} <= 2'h3;
		w(6);
		chk(CPU_EN, 0);
		SUPPLY_ABOVE_LOCKOUT <= 1;
		boot(4'h3);
		chk({CONFIG_LOAD_REQ, UPDATE_MODE}, 2'h2);
		apb(1, `OFF_CTRL, 32'h0000_0005);
		w(2);
		chk(PORT_B_EN, 1);
		foreach (rows[i]) begin
			SENSORS <= rows[i].s;
			w(5);
			chk({BUCKBOOST_EN, PORT_A_CABLE_POWER_EN, PORT_B_CABLE_POWER_EN, DISCHARGE_EN} & rows[i].m, 0);
			chk(ERROR_RECOVERY, 1);
			SENSORS <= '0;
			apb(0, `OFF_STATUS, 0);
			chk(q[rows[i].b], 1);
			w(4);
			apb(1, `OFF_STATUS, 32'h0000_0001 << rows[i].b);
			apb(0, `OFF_STATUS, 0);
			chk(q[rows[i].b], 0);
		end
		apb(1, `OFF_STATUS, 32'h0000_03FF);
		w(1);
		chk(IRQ, 0);
		SENSORS <= 5'h10;
		w(5);
		chk(IRQ, 1);
		apb(1, `OFF_MASK, 32'h0000_03FF);
		w(1);
		chk(IRQ, 0);
		apb(1, `OFF_MASK, 32'h0000_0000);
		SENSORS <= '0;
		w(4);
		apb(1, `OFF_STATUS, 32'h0000_03FF);
		w(1);
		chk(IRQ, 0);
		for (int k = 0; k < 3; k++) begin
			TEMPERATURE_SENSE_INPUT <= 3'h1 << k;
			w(5);
			apb(0, `OFF_STATUS, 0);
			chk(q[5 + k], 1);
		end
		apb(0, 12'h0FC, 0);
		chk(q, 0);
		apb(0, `OFF_MEMINFO, 0);
		chk(q, 32'h00A0_001B);
		apb(0, `OFF_BOOT, 0);
		chk(q, 32'h0000_0350);
		chk({PSLVERR, CONFIG_MEM_ADDR}, 8'h50);
		SENSORS <= 5'h02;
		BUS_FALLING <= 1;
		w(5);
		chk(DISCHARGE_EN, 0);
		SENSORS <= '0;
		w(5);
		chk(DISCHARGE_EN, 0);
		BUS_ABOVE_DISCH_THRESHOLD <= 1;
		w(5);
		chk(DISCHARGE_EN, 1);
		{SENSORS, OVERTEMP_HYSTERESIS} <= {5'h01, 1'b0};
		w(5);
		chk({CPU_RESET, CPU_EN}, 2'h2);
		SENSORS <= '0;
		w(5);
		chk(CPU_EN, 0);
		OVERTEMP_HYSTERESIS <= 1;
		boot(4'h8);
		w(1);
		chk(UPDATE_MODE, 1);
		ENABLE_UNDERVOLTAGE_INPUT <= 0;
		w(3);
		chk(CPU_EN, 0);
		ENABLE_UNDERVOLTAGE_INPUT <= 1;
		boot(4'h3);
		apb(1, `OFF_CTRL, 32'h0000_0006);
		w(2);
		chk(PORT_B_EN, 0);
		SYS_RST <= 1;
		w(2);
		chk(CPU_RESET, 1);
		SYS_RST <= 0;
		w(2);
		stop_test();
	end
endmodule
